// file: src/rsfi_top.sv
// Notes on behaviour
// - Qualified undervoltage sets its flag, kept through reset.
// - Cause flags sticky; only written zero or power-on clears.
// - Undefined voltage-select code sets its flag, resets.
// - Upper four flag bits read zero.
// - Writing 55H to flash control resets chip.
// - Running watchdog time-out sets time-out flag.
// - Sleeping time-out: clear PC, SP; set both.
// - Power-on clears both; undervoltage keeps; running watchdog sets time-out.
// - Reset disables every interrupt.
// - Reset loads port data and direction ones.
// - Reset points stack pointer at top.
// - Illegal reset-control value sets its flag.
// - Illegal reset-control value resets after delay.
`timescale 1ns/1ps
module rsfi_top #(
  parameter int unsigned UV_CYCLES = rsfi_pkg::UV_CYCLES_DEF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire rsfi_pkg::rsfi_bus_req_t  bus_req,
  output logic [7:0]                    rdata,
  input  wire logic                     supply_low,
  input  wire logic                     wdt_timeout,
  input  wire logic                     wdt_ctrl_error,
  input  wire logic                     low_power,
  output logic                          device_reset,
  output logic                          periph_init,
  output logic                          pc_sp_clear,
  output logic [rsfi_pkg::SP_W-1:0]     stack_ptr,
  output logic [7:0]                    port_data,
  output logic [7:0]                    port_dir,
  output logic                          irq
);

  // Sequencer state.
  rsfi_pkg::rsfi_state_t state;       // Current sequencer state.
  rsfi_pkg::rsfi_state_t next_state;  // Next sequencer state.
  logic [11:0]           cnt;         // Delay counter for soft resets.
  logic [11:0]           next_cnt;    // Next delay count.
  rsfi_pkg::rsfi_cause_t cause;       // Causes carried by the pending reset.
  rsfi_pkg::rsfi_cause_t next_cause;  // Next causes.
  rsfi_pkg::rsfi_cause_t imm;         // Causes that reset at once.
  logic                  any_imm;     // Some immediate cause present.
  logic                  rctl_bad;    // Reset control holds an illegal value.
  logic                  vsel_level;  // Voltage select holds a defined level.
  logic                  vsel_bad;    // Voltage select holds an undefined code.
  logic                  uv_en;       // Undervoltage detector armed.
  logic                  uv_reset;    // Qualified undervoltage.
  logic                  ev_sleep;    // Watchdog time-out while in low power.

  // Software-visible registers.
  logic [3:0]            flags;            // Reset cause flags.
  logic [3:0]            next_flags;
  logic [7:0]            rctl;             // Reset control register.
  logic [7:0]            next_rctl;
  logic [7:0]            vsel;             // Voltage select register.
  logic [7:0]            next_vsel;
  logic [7:0]            fct2;             // Second flash control register.
  logic [7:0]            next_fct2;
  logic                  to;               // Time-out status flag.
  logic                  next_to;
  logic                  pdn;              // Power-down flag.
  logic                  next_pdn;
  logic [4:0]            irq_stat;         // Sticky interrupt status.
  logic [4:0]            next_irq_stat;
  logic [4:0]            irq_mask;         // Interrupt enables.
  logic [4:0]            next_irq_mask;
  logic [7:0]            next_port_data;
  logic [7:0]            next_port_dir;
  logic [rsfi_pkg::SP_W-1:0] next_stack_ptr;
  logic                  next_pc_sp_clear;
  logic                  next_periph_init;
  logic [7:0]            next_rdata;
  logic                  fire;             // Full device reset this cycle.

  // Duration filter on the asynchronous supply comparator.
  rsfi_uv_qualify #(
    .UV_CYCLES  (UV_CYCLES)
  ) u_uv (
    .clock      (clock),
    .rst        (rst),
    .supply_low (supply_low),
    .enable     (uv_en),
    .uv_reset   (uv_reset)
  );

  // Classify control codes and present events.
  always_comb begin
    rctl_bad   = (rctl != rsfi_pkg::RCTL_NOPA) && (rctl != rsfi_pkg::RCTL_NOPB);
    vsel_level = (vsel == rsfi_pkg::VSEL_V1) || (vsel == rsfi_pkg::VSEL_V2) ||
                 (vsel == rsfi_pkg::VSEL_V3) || (vsel == rsfi_pkg::VSEL_V4) ||
                 (vsel == rsfi_pkg::VSEL_V5);
    vsel_bad   = !vsel_level && (vsel != rsfi_pkg::VSEL_OFF);
    // The detector sleeps with the core, so low power disarms it.
    uv_en      = vsel_level && !low_power;
    imm        = '0;
    imm.uv     = uv_reset;
    imm.wde    = wdt_ctrl_error;
    imm.wdt    = wdt_timeout && !low_power;
    imm.prog   = rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_FCT2) &&
                 (bus_req.wdata == rsfi_pkg::PROG_MAGIC);
    any_imm    = imm.uv || imm.wde || imm.wdt || imm.prog;
    ev_sleep   = wdt_timeout && low_power;
    fire       = (state == rsfi_pkg::RSFI_FIRE);
  end

  // Sequencer: immediate causes fire next cycle, illegal codes wait out the delay.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cause = cause;
    case (state)
      rsfi_pkg::RSFI_RUN: begin
        if (any_imm) begin
          next_state = rsfi_pkg::RSFI_FIRE;
          next_cause = imm;
        end else if (rctl_bad || vsel_bad) begin
          // Illegal value starts the delay.
          next_state      = rsfi_pkg::RSFI_WAIT;
          next_cnt        = 12'h000;
          next_cause      = '0;
          next_cause.rctl = rctl_bad;
          next_cause.vse  = vsel_bad;
        end
      end
      rsfi_pkg::RSFI_WAIT: begin
        // A repaired code does not cancel the pending reset.
        next_cnt        = cnt + 12'h001;
        next_cause.rctl = cause.rctl || rctl_bad;
        next_cause.vse  = cause.vse || vsel_bad;
        if (any_imm) begin
          next_state = rsfi_pkg::RSFI_FIRE;
          next_cause = next_cause | imm;
        end else if (cnt == rsfi_pkg::SRESET_LAST) begin
          next_state = rsfi_pkg::RSFI_FIRE;
        end
      end
      rsfi_pkg::RSFI_FIRE: begin
        next_state = rsfi_pkg::RSFI_RUN;
        next_cause = '0;
      end
      default: begin
        next_state = rsfi_pkg::RSFI_RUN;
        next_cause = '0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= rsfi_pkg::RSFI_RUN;
      cnt   <= 12'h000;
      cause <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      cause <= next_cause;
    end
  end

  // Register file: software writes first, then hardware sets and reset loads on top.
  always_comb begin
    next_flags       = flags;
    next_rctl        = rctl;
    next_vsel        = vsel;
    next_fct2        = fct2;
    next_to          = to;
    next_pdn         = pdn;
    next_irq_stat    = irq_stat;
    next_irq_mask    = irq_mask;
    next_port_data   = port_data;
    next_port_dir    = port_dir;
    next_stack_ptr   = stack_ptr;
    next_pc_sp_clear = 1'b0;
    next_periph_init = fire;
    // Writing zero clears a flag, writing one keeps it.
    if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_FLAGS)) begin
      next_flags = flags & bus_req.wdata[3:0];
    end
    // Interrupt status clears by writing one.
    if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~bus_req.wdata[4:0];
    end
    // Other writes are lost in the reset cycle, which reloads those registers, except vsel when an undervoltage keeps it.
    if (!fire) begin
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_RCTL)) begin
        next_rctl = bus_req.wdata;
      end
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_VSEL)) begin
        next_vsel = bus_req.wdata;
      end
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_FCT2)) begin
        next_fct2 = bus_req.wdata;
      end
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_IRQ_MASK)) begin
        next_irq_mask = bus_req.wdata[4:0];
      end
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_PORT_DATA)) begin
        next_port_data = bus_req.wdata;
      end
      if (rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_PORT_DIR)) begin
        next_port_dir = bus_req.wdata;
      end
      // Sleeping time-out wakes the core without a full reset.
      if (ev_sleep) begin
        next_to          = 1'b1;
        next_pdn         = 1'b1;
        next_stack_ptr   = rsfi_pkg::SP_ZERO;
        next_pc_sp_clear = 1'b1;
        next_irq_stat[rsfi_pkg::BIT_WAKE] = 1'b1;
      end
    end else begin
      // Full reset reloads ports, controls and enables.
      next_rctl      = rsfi_pkg::RCTL_POR;
      next_fct2      = rsfi_pkg::FCT2_POR;
      next_irq_mask  = rsfi_pkg::IRQ_POR;
      next_port_data = rsfi_pkg::PORT_POR;
      next_port_dir  = rsfi_pkg::PORT_POR;
      next_stack_ptr = rsfi_pkg::SP_TOP;
      // An undervoltage without a vse, wdt or rctl cause keeps the chosen level.
      if (!cause.uv || cause.vse || cause.wdt || cause.rctl) begin
        next_vsel = rsfi_pkg::VSEL_POR;
      end
      // Undervoltage leaves both status flags alone.
      if (cause.wdt) begin
        next_to = 1'b1;
      end
      // Sets come after the clear above, so they win.
      next_flags[rsfi_pkg::BIT_SRC] = next_flags[rsfi_pkg::BIT_SRC] | cause.rctl;
      next_flags[rsfi_pkg::BIT_UVR] = next_flags[rsfi_pkg::BIT_UVR] | cause.uv;
      next_flags[rsfi_pkg::BIT_VSE] = next_flags[rsfi_pkg::BIT_VSE] | cause.vse;
      next_flags[rsfi_pkg::BIT_WDE] = next_flags[rsfi_pkg::BIT_WDE] | cause.wde;
      next_irq_stat[3:0] = next_irq_stat[3:0] | {cause.rctl, cause.uv, cause.vse, cause.wde};
    end
  end

  // Read data stand in the cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        rsfi_pkg::OFF_FLAGS:     next_rdata = {4'h0, flags};
        rsfi_pkg::OFF_RCTL:      next_rdata = rctl;
        rsfi_pkg::OFF_VSEL:      next_rdata = vsel;
        rsfi_pkg::OFF_FCT2:      next_rdata = fct2;
        rsfi_pkg::OFF_STATUS:    next_rdata = {6'h00, to, pdn};
        rsfi_pkg::OFF_IRQ_STAT:  next_rdata = {3'h0, irq_stat};
        rsfi_pkg::OFF_IRQ_MASK:  next_rdata = {3'h0, irq_mask};
        rsfi_pkg::OFF_PORT_DATA: next_rdata = port_data;
        rsfi_pkg::OFF_PORT_DIR:  next_rdata = port_dir;
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  // Register file flip-flops; the power-on reset is the only one that clears flags.
  always_ff @(posedge clock) begin
    if (rst) begin
      flags       <= rsfi_pkg::FLAGS_POR;
      rctl        <= rsfi_pkg::RCTL_POR;
      vsel        <= rsfi_pkg::VSEL_POR;
      fct2        <= rsfi_pkg::FCT2_POR;
      to          <= 1'b0;
      pdn         <= 1'b0;
      irq_stat    <= rsfi_pkg::IRQ_POR;
      irq_mask    <= rsfi_pkg::IRQ_POR;
      port_data   <= rsfi_pkg::PORT_POR;
      port_dir    <= rsfi_pkg::PORT_POR;
      stack_ptr   <= rsfi_pkg::SP_TOP;
      pc_sp_clear <= 1'b0;
      periph_init <= 1'b1;
      rdata       <= 8'h00;
    end else begin
      flags       <= next_flags;
      rctl        <= next_rctl;
      vsel        <= next_vsel;
      fct2        <= next_fct2;
      to          <= next_to;
      pdn         <= next_pdn;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      port_data   <= next_port_data;
      port_dir    <= next_port_dir;
      stack_ptr   <= next_stack_ptr;
      pc_sp_clear <= next_pc_sp_clear;
      periph_init <= next_periph_init;
      rdata       <= next_rdata;
    end
  end

  // Reset strobe straight from the full compare of the state with RSFI_FIRE.
  assign device_reset = fire;
  // Level interrupt while any enabled status bit stands.
  assign irq = |(irq_stat & irq_mask);

  a_uv_flag: assert property (@(posedge clock) disable iff (rst)
    (uv_reset && !fire) |=> device_reset ##1 flags[rsfi_pkg::BIT_UVR])
    else $error("undervoltage did not reset and set its flag");

  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    $fell(flags[rsfi_pkg::BIT_VSE]) |->
      $past(rsfi_pkg::rsfi_wr_hit(bus_req, rsfi_pkg::OFF_FLAGS) && !bus_req.wdata[rsfi_pkg::BIT_VSE]))
    else $error("cause flag fell without a zero write");

  a_vsel_flag: assert property (@(posedge clock) disable iff (rst)
    (fire && cause.vse) |=> flags[rsfi_pkg::BIT_VSE] && (vsel == rsfi_pkg::VSEL_POR))
    else $error("voltage select error not recorded");

  a_upper_zero: assert property (@(posedge clock) disable iff (rst)
    rsfi_pkg::rsfi_rd_hit(bus_req, rsfi_pkg::OFF_FLAGS) |=> (rdata[7:4] == 4'h0) && (rdata[3:0] == flags))
    else $error("flag read shows wrong bits");

  a_prog_reset: assert property (@(posedge clock) disable iff (rst)
    (imm.prog && !fire) |=> device_reset ##1 (fct2 == rsfi_pkg::FCT2_POR))
    else $error("flash control magic write did not reset");

  a_wdt_run: assert property (@(posedge clock) disable iff (rst)
    (wdt_timeout && !low_power && !fire) |=> device_reset ##1 (to && periph_init))
    else $error("running time-out did not reset and set flag");

  a_wdt_sleep: assert property (@(posedge clock) disable iff (rst)
    (ev_sleep && !fire) |=> pc_sp_clear && to && pdn && (stack_ptr == rsfi_pkg::SP_ZERO))
    else $error("sleeping time-out handled wrongly");

  a_por_state: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> !to && !pdn && (flags == rsfi_pkg::FLAGS_POR) && (irq_mask == rsfi_pkg::IRQ_POR))
    else $error("power-on state wrong");

  a_init_load: assert property (@(posedge clock) disable iff (rst)
    device_reset |=> (port_data == rsfi_pkg::PORT_POR) && (port_dir == rsfi_pkg::PORT_POR) &&
      (stack_ptr == rsfi_pkg::SP_TOP) && !irq && periph_init)
    else $error("reset did not initialise ports, stack or interrupts");

  a_rctl_wait: assert property (@(posedge clock) disable iff (rst)
    (state == rsfi_pkg::RSFI_RUN && rctl_bad && !any_imm) |=> (state == rsfi_pkg::RSFI_WAIT) [*8])
    else $error("illegal reset control not delayed");

  a_set_wins: assert property (@(posedge clock) disable iff (rst)
    (fire && cause.rctl) |=> flags[rsfi_pkg::BIT_SRC])
    else $error("reset control flag lost");

endmodule : rsfi_top

// file: src/rsfi_pkg.sv
// Shared constants and types for the reset-source flag and initialisation block.
package rsfi_pkg;

  // System clock period in nanoseconds (100 MHz).
  localparam int unsigned CLK_PERIOD_NS  = 10;

  // Delay from an illegal control code to the reset, in nanoseconds.
  localparam int unsigned T_SRESET_NS    = 40000;
  // Delay in whole cycles, rounded up.
  localparam int unsigned SRESET_CYCLES  = (T_SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Last count value of the delay counter.
  localparam logic [11:0] SRESET_LAST    = 12'(SRESET_CYCLES - 1);

  // Least low-supply duration that qualifies, in nanoseconds.
  localparam int unsigned T_UV_NS        = 120000;
  // Qualifying duration in whole cycles, rounded up.
  localparam int unsigned UV_CYCLES_DEF  = (T_UV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets on the software port.
  localparam logic [7:0] OFF_FLAGS     = 8'h00;
  localparam logic [7:0] OFF_RCTL      = 8'h01;
  localparam logic [7:0] OFF_VSEL      = 8'h02;
  localparam logic [7:0] OFF_FCT2      = 8'h03;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h05;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h06;
  localparam logic [7:0] OFF_PORT_DATA = 8'h07;
  localparam logic [7:0] OFF_PORT_DIR  = 8'h08;

  // Bit positions in the reset cause flags and the interrupt status.
  localparam int unsigned BIT_WDE   = 0;
  localparam int unsigned BIT_VSE   = 1;
  localparam int unsigned BIT_UVR   = 2;
  localparam int unsigned BIT_SRC   = 3;
  localparam int unsigned BIT_WAKE  = 4;
  // Bit positions in the status register.
  localparam int unsigned BIT_PDN   = 0;
  localparam int unsigned BIT_TO    = 1;

  // Values after reset and special codes.
  localparam logic [3:0] FLAGS_POR = 4'h0;
  localparam logic [4:0] IRQ_POR   = 5'h00;
  localparam logic [7:0] RCTL_POR  = 8'h55;
  localparam logic [7:0] RCTL_NOPA = 8'h55;
  localparam logic [7:0] RCTL_NOPB = 8'hAA;
  localparam logic [7:0] VSEL_POR  = 8'h66;
  localparam logic [7:0] VSEL_V1   = 8'h66;
  localparam logic [7:0] VSEL_V2   = 8'h55;
  localparam logic [7:0] VSEL_V3   = 8'h33;
  localparam logic [7:0] VSEL_V4   = 8'h99;
  localparam logic [7:0] VSEL_V5   = 8'hAA;
  localparam logic [7:0] VSEL_OFF  = 8'hF0;
  localparam logic [7:0] FCT2_POR  = 8'h00;
  localparam logic [7:0] PROG_MAGIC = 8'h55;
  localparam logic [7:0] PORT_POR  = 8'hFF;
  localparam int unsigned SP_W     = 3;
  localparam logic [2:0] SP_TOP    = 3'h7;
  localparam logic [2:0] SP_ZERO   = 3'h0;

  // One software access, write or read.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsfi_bus_req_t;

  // Causes that a pending or firing reset carries.
  typedef struct packed {
    logic rctl;
    logic uv;
    logic vse;
    logic wde;
    logic wdt;
    logic prog;
  } rsfi_cause_t;

  // Reset sequencer states.
  typedef enum logic [2:0] {
    RSFI_RUN  = 3'b001,
    RSFI_WAIT = 3'b010,
    RSFI_FIRE = 3'b100
  } rsfi_state_t;

  // True for a write to the given offset.
  function automatic logic rsfi_wr_hit(input rsfi_bus_req_t r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction : rsfi_wr_hit

  // True for a read of the given offset.
  function automatic logic rsfi_rd_hit(input rsfi_bus_req_t r, input logic [7:0] off);
    return r.rd && (r.addr == off);
  endfunction : rsfi_rd_hit

endpackage : rsfi_pkg

// file: src/rsfi_uv_qualify.sv
`timescale 1ns/1ps
// Synchronises the supply comparator and asks for a reset only after it stays low long enough.
module rsfi_uv_qualify #(
  parameter int unsigned UV_CYCLES = rsfi_pkg::UV_CYCLES_DEF
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic supply_low,
  input  wire logic enable,
  output logic      uv_reset
);
  // Last value of the duration counter.
  localparam logic [15:0] LAST = 16'(UV_CYCLES - 1);

  logic [2:0]  sync;         // Three-stage synchroniser, stage 0 first.
  logic        stable;       // Accepted comparator level.
  logic        next_stable;  // Next accepted level.
  logic [15:0] count;        // Cycles of qualified low supply.
  logic [15:0] next_count;   // Next count.
  logic        next_uv;      // Next reset request.

  // A level change is accepted only when stages two and three agree, so a glitch is dropped.
  always_comb begin
    next_stable = stable;
    next_count  = 16'h0000;
    next_uv     = 1'b0;
    if (sync[1] == sync[2]) begin
      next_stable = sync[2];
    end
    // Short dips restart the count and never reset the chip.
    if (enable && stable) begin
      if (count == LAST) begin
        next_count = count;
        next_uv    = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clock) begin
    if (rst) begin
      sync     <= 3'h0;
      stable   <= 1'b0;
      count    <= 16'h0000;
      uv_reset <= 1'b0;
    end else begin
      sync     <= {sync[1:0], supply_low};
      stable   <= next_stable;
      count    <= next_count;
      uv_reset <= next_uv;
    end
  end

endmodule : rsfi_uv_qualify

// file: verif/tb_rsfi_top.sv
`timescale 1ns/1ps
// Self-checking bench: software accesses and event pulses against expected register images.
module tb_rsfi_top;
  localparam int unsigned UV_SIM  = 20;                   // Short qualify time keeps the run brief.
  localparam int unsigned SR      = rsfi_pkg::SRESET_CYCLES; // Delayed reset span.
  logic                    clock;           // System clock.
  logic                    rst;             // Power-on reset.
  rsfi_pkg::rsfi_bus_req_t bus_req;         // Software access.
  logic [7:0]              rdata;           // Read data.
  logic                    supply_low;      // Supply comparator.
  logic                    wdt_timeout;     // Watchdog time-out pulse.
  logic                    wdt_ctrl_error;  // Watchdog control error pulse.
  logic                    low_power;       // Core asleep.
  logic                    device_reset;    // Whole-device reset.
  logic                    periph_init;     // Peripheral initialise.
  logic                    pc_sp_clear;     // Sleeping time-out clear.
  logic [2:0]              stack_ptr;       // Stack pointer.
  logic [7:0]              port_data;       // Port data.
  logic [7:0]              port_dir;        // Port direction.
  logic                    irq;             // Interrupt line.
  int                      err_total;       // Mismatches.
  int                      samples_checked; // Comparisons.
  int                      n;               // Cycles waited for a reset.
  logic [7:0]              rd_val;          // Last value read.
  logic [7:0]              st;              // Saved status image.

  rsfi_top #(.UV_CYCLES(UV_SIM)) dut_u (
    .clock          (clock),
    .rst            (rst),
    .bus_req        (bus_req),
    .rdata          (rdata),
    .supply_low     (supply_low),
    .wdt_timeout    (wdt_timeout),
    .wdt_ctrl_error (wdt_ctrl_error),
    .low_power      (low_power),
    .device_reset   (device_reset),
    .periph_init    (periph_init),
    .pc_sp_clear    (pc_sp_clear),
    .stack_ptr      (stack_ptr),
    .port_data      (port_data),
    .port_dir       (port_dir),
    .irq            (irq)
  );

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compares one value; four-state compare so an unknown never passes.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; the slave never stalls.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : bus_wr

  // One-cycle read strobe; data stand only in the following cycle.
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1;
    rd_val = rdata;
  endtask : bus_rd

  // One-cycle event pulse: zero for watchdog time-out, otherwise control error.
  task automatic pulse(input int k);
    @(posedge clock);
    if (k == 0) begin
      wdt_timeout <= 1'b1;
    end else begin
      wdt_ctrl_error <= 1'b1;
    end
    @(posedge clock);
    wdt_timeout    <= 1'b0;
    wdt_ctrl_error <= 1'b0;
  endtask : pulse

  // Counts cycles until the reset pulse shows, bounded so a missing reset cannot hang.
  task automatic wait_rst(input int lim);
    n = 0;
    #1;
    while (device_reset !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : wait_rst

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Cuts a hang short; the tests need about 8200 cycles.
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    bus_req = '0;
    supply_low = 1'b0;
    wdt_timeout = 1'b0;
    wdt_ctrl_error = 1'b0;
    low_power = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("port_dir", 8'hFF, port_dir);
    chk("stack_ptr", 8'h07, 8'(stack_ptr));
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h00, rd_val);
    bus_rd(rsfi_pkg::OFF_STATUS); chk("status", 8'h00, rd_val);
    bus_rd(rsfi_pkg::OFF_IRQ_MASK); chk("mask", 8'h00, rd_val);
    bus_rd(8'h3C); chk("unmapped", 8'h00, rd_val);
    // Dirty the ports and mask, then the flash magic write must restore them.
    bus_wr(rsfi_pkg::OFF_PORT_DATA, 8'h00);
    bus_wr(rsfi_pkg::OFF_PORT_DIR, 8'h0F);
    bus_wr(rsfi_pkg::OFF_IRQ_MASK, 8'h1F);
    bus_wr(rsfi_pkg::OFF_FCT2, 8'h55); wait_rst(3); chk("magic delay", 8'h00, 8'(n));
    @(posedge clock);
    #1;
    chk("periph_init", 8'h01, 8'(periph_init));
    chk("port_data", 8'hFF, port_data);
    chk("port_dir", 8'hFF, port_dir);
    chk("stack_ptr", 8'h07, 8'(stack_ptr));
    bus_rd(rsfi_pkg::OFF_IRQ_MASK); chk("mask", 8'h00, rd_val);
    // Watchdog time-out while running.
    pulse(0); wait_rst(3); chk("wdt delay", 8'h00, 8'(n));
    bus_rd(rsfi_pkg::OFF_STATUS); chk("status", 8'h02, rd_val);
    // Watchdog time-out while asleep: no full reset, wake interrupt raised.
    bus_wr(rsfi_pkg::OFF_IRQ_MASK, 8'h10);
    low_power <= 1'b1;
    pulse(0);
    #1;
    chk("pc_sp_clear", 8'h01, 8'(pc_sp_clear));
    chk("no reset", 8'h00, 8'(device_reset));
    @(posedge clock);
    #1;
    chk("stack_ptr", 8'h00, 8'(stack_ptr));
    chk("irq", 8'h01, 8'(irq));
    low_power <= 1'b0;
    bus_rd(rsfi_pkg::OFF_STATUS); chk("status", 8'h03, rd_val);
    bus_wr(rsfi_pkg::OFF_IRQ_MASK, 8'h00); #1; chk("irq masked", 8'h00, 8'(irq));
    bus_wr(rsfi_pkg::OFF_IRQ_STAT, 8'h10);
    bus_wr(rsfi_pkg::OFF_IRQ_MASK, 8'h10); #1; chk("irq cleared", 8'h00, 8'(irq));
    // Control error flag: sticky, writing ones keeps it, upper bits read zero.
    pulse(1); wait_rst(3);
    bus_wr(rsfi_pkg::OFF_FLAGS, 8'hFF);
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h01, rd_val);
    bus_wr(rsfi_pkg::OFF_FLAGS, 8'h00);
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h00, rd_val);
    // Set and a zero write land together: the set must win.
    @(posedge clock);
    wdt_ctrl_error <= 1'b1;
    @(posedge clock);
    wdt_ctrl_error <= 1'b0;
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: rsfi_pkg::OFF_FLAGS, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h01, rd_val);
    bus_wr(rsfi_pkg::OFF_FLAGS, 8'h00);
    // A permitted control pattern causes no reset.
    bus_wr(rsfi_pkg::OFF_RCTL, 8'hAA); wait_rst(40); chk("no reset", 8'h00, 8'(device_reset));
    // Illegal control pattern resets after the delay and sets its flag.
    bus_wr(rsfi_pkg::OFF_RCTL, 8'h12); wait_rst(SR + 20);
    chk("rctl delay", 8'h01, 8'(n >= SR - 2 && n <= SR + 1));
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h08, rd_val);
    bus_rd(rsfi_pkg::OFF_RCTL); chk("rctl", 8'h55, rd_val);
    bus_wr(rsfi_pkg::OFF_FLAGS, 8'h00);
    // Undefined voltage-select code resets after the delay and reloads the register.
    bus_wr(rsfi_pkg::OFF_VSEL, 8'h12); wait_rst(SR + 20);
    chk("vsel delay", 8'h01, 8'(n >= SR - 2 && n <= SR + 1));
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h02, rd_val);
    bus_rd(rsfi_pkg::OFF_VSEL); chk("vsel", 8'h66, rd_val);
    bus_wr(rsfi_pkg::OFF_FLAGS, 8'h00);
    // Qualified undervoltage: flag set, status and voltage select untouched.
    bus_wr(rsfi_pkg::OFF_VSEL, 8'h55);
    bus_rd(rsfi_pkg::OFF_STATUS);
    st = rd_val;
    @(posedge clock);
    supply_low <= 1'b1;
    wait_rst(UV_SIM + 40); chk("uv qualify", 8'h01, 8'(n >= UV_SIM && n < UV_SIM + 40));
    supply_low <= 1'b0;
    repeat (20) @(posedge clock);
    bus_rd(rsfi_pkg::OFF_FLAGS); chk("flags", 8'h04, rd_val);
    bus_rd(rsfi_pkg::OFF_STATUS); chk("status", st, rd_val);
    bus_rd(rsfi_pkg::OFF_VSEL); chk("vsel", 8'h55, rd_val);
    wrap_up();
  end

endmodule : tb_rsfi_top
